// File: hdl/tlc_host.sv
// tlc_host.sv: tagged link command engine facing another module's protocol engine
// assumes: link words arrive on mclk from same-clock logic; user side is valid/ready
`timescale 1ns/1ps
`include "tlc_regs.svh"

// What this block does
// - response byte word carries opcode 08
// - responder sends one word per byte, then terminator
// - terminator is 0900 and ends responses
// - initiator tag announcement uses opcode 0A
// - tag: free upper nibble, link type below
// - announce initiator tag only after acceptance
// - responder tag announcement uses opcode 0B
// - responder tag follows its acceptance
// - link selection uses opcode 0C
// - select before data on a different link
// - selection carries the receiver's announced tag
// - establishment is 0E0x with type nibble
// - types: keyboard graphics control storage data
// - acceptance is 030x with the type
// - rejection is 040x with the type
module tlc_host
  import tlc_pkg::*;
#(
  parameter logic [3:0] OWN_NIBBLE = `TLC_OWN_NIBBLE,
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tlc_cmd_s cmd,
  output logic tx_valid,
  input wire logic tx_ready,
  output tlc_word_s tx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire tlc_word_s rx_data,
  output logic out_valid,
  input wire logic out_ready,
  output tlc_out_s out_data,
  output logic [`TLC_LINK_TYPES-1:0] link_up,
  output logic protocol_violation_flag,
  output logic link_rejected,
  output logic cmd_refused
);

  // =====================================================================
  // state
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_EST_WAIT = 3'b001,
    S_TAG_WAIT = 3'b010,
    S_ACC_TAG = 3'b011,
    S_DATA = 3'b100,
    S_QUERY = 3'b101
  } tlc_state_e;

  tlc_state_e state;
  tlc_state_e next_state;
  tlc_word_s next_tx_data;
  logic next_tx_valid;
  logic [2:0] pend_type;
  logic [15:0] pend_word;
  logic [7:0] peer_tag [`TLC_LINK_TYPES];
  logic [2:0] tx_link;
  logic tx_link_set;
  logic [2:0] rx_link;
  logic sel_sent;
  logic refuse;

  // =====================================================================
  // link word decode
  wire [7:0] rx_opc = rx_data.word[`TLC_OPC_MSB:`TLC_OPC_LSB];
  wire [7:0] rx_arg = rx_data.word[`TLC_ARG_MSB:`TLC_ARG_LSB];
  wire [2:0] rx_type = rx_arg[2:0];
  wire rx_type_ok = (rx_arg[7:4] == 4'h0) && (rx_arg[3:0] <= `TLC_LAST_TYPE);
  wire tag_type_ok = (rx_arg[3:0] <= `TLC_LAST_TYPE);
  wire rx_fire = rx_valid && rx_ready;
  wire rx_cmd = rx_fire && !rx_data.is_data;
  wire hit_resp = rx_cmd && (rx_opc == `TLC_OPC_RESP);
  wire hit_end = rx_cmd && (rx_data.word == `TLC_WORD_RESP_END);
  wire hit_acc = rx_cmd && (rx_opc == `TLC_OPC_ACCEPT);
  wire hit_rej = rx_cmd && (rx_opc == `TLC_OPC_REJECT);
  wire hit_itag = rx_cmd && (rx_opc == `TLC_OPC_INIT_TAG);
  wire hit_rtag = rx_cmd && (rx_opc == `TLC_OPC_RESP_TAG);
  wire hit_sel = rx_cmd && (rx_opc == `TLC_OPC_SELECT);
  wire hit_est = rx_cmd && (rx_opc == `TLC_OPC_ESTABLISH);
  wire pend_match = (rx_arg == {5'h00, pend_type});
  wire answer_ok = (state == S_EST_WAIT) && pend_match;
  wire rtag_ok = (state == S_TAG_WAIT) && (rx_arg[3:0] == {1'b0, pend_type});
  wire sel_ok = (rx_arg[7:4] == OWN_NIBBLE) && tag_type_ok;
  wire in_query = (state == S_QUERY);
  // responses only count while a query is outstanding
  wire viol = ((hit_resp || hit_end) && !in_query)
    || ((hit_acc || hit_rej) && !answer_ok)
    || (hit_rtag && !rtag_ok)
    || (hit_itag && !tag_type_ok)
    || (hit_sel && !sel_ok);

  // =====================================================================
  // user side and link handshakes
  wire buf_in_ready;
  wire [7:0] own_tag_of_pend = {OWN_NIBBLE, 1'b0, pend_type};
  wire busy_emit = (state == S_ACC_TAG) || (state == S_DATA);
  // link input waits for a free transmit slot so any answer never collides
  assign rx_ready = !tx_valid && !busy_emit && buf_in_ready;
  assign cmd_ready = (state == S_IDLE) && !tx_valid && !rx_valid;
  wire cmd_fire = cmd_valid && cmd_ready;
  wire sel_needed = !tx_link_set || (tx_link != cmd.ltype);
  wire cmd_type_ok = ({1'b0, cmd.ltype} <= `TLC_LAST_TYPE);

  // responses and link data to the user through the buffer
  wire push = (hit_resp && in_query) || (hit_end && in_query)
    || (rx_fire && rx_data.is_data);
  tlc_out_s push_data;
  assign push_data.kind = rx_data.is_data ? TLC_OUT_DATA
    : (hit_end ? TLC_OUT_RESP_END : TLC_OUT_RESP_BYTE);
  assign push_data.ltype = rx_link;
  assign push_data.word = rx_data.is_data ? rx_data.word : {8'h00, rx_arg};

  tlc_buf #(
    .WIDTH($bits(tlc_out_s)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .mclk(mclk),
    .reset(reset),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // =====================================================================
  // sequencing
  always_comb
  begin
    next_state = state;
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_data = tx_data;
    sel_sent = 1'b0;
    refuse = 1'b0;
    case (state)
      S_IDLE:
      begin
        if (hit_est)
        begin
          next_tx_valid = 1'b1;
          next_tx_data = '{1'b0, {rx_type_ok ? `TLC_OPC_ACCEPT : `TLC_OPC_REJECT, rx_arg}};
          next_state = rx_type_ok ? S_ACC_TAG : S_IDLE;
        end
        else if (cmd_fire)
        begin
          case (cmd.op)
            TLC_REQ_ESTABLISH:
            begin
              if (cmd_type_ok)
              begin
                next_tx_valid = 1'b1;
                next_tx_data = '{1'b0, {`TLC_OPC_ESTABLISH, 5'h00, cmd.ltype}};
                next_state = S_EST_WAIT;
              end
              else
              begin
                refuse = 1'b1;
              end
            end
            TLC_REQ_DATA:
            begin
              if (!cmd_type_ok || !link_up[cmd.ltype])
              begin
                refuse = 1'b1;
              end
              else if (sel_needed)
              begin
                next_tx_valid = 1'b1;
                next_tx_data = '{1'b0, {`TLC_OPC_SELECT, peer_tag[cmd.ltype]}};
                sel_sent = 1'b1;
                next_state = S_DATA;
              end
              else
              begin
                next_tx_valid = 1'b1;
                next_tx_data = '{1'b1, cmd.word};
              end
            end
            TLC_REQ_QUERY:
            begin
              next_tx_valid = 1'b1;
              next_tx_data = '{1'b0, cmd.word};
              next_state = S_QUERY;
            end
            default:
            begin
              refuse = 1'b1;
            end
          endcase
        end
      end
      S_ACC_TAG:
      begin
        if (!tx_valid)
        begin
          next_tx_valid = 1'b1;
          next_tx_data = '{1'b0, {`TLC_OPC_RESP_TAG, own_tag_of_pend}};
          next_state = S_IDLE;
        end
      end
      S_EST_WAIT:
      begin
        if (hit_acc && answer_ok)
        begin
          next_tx_valid = 1'b1;
          next_tx_data = '{1'b0, {`TLC_OPC_INIT_TAG, own_tag_of_pend}};
          next_state = S_TAG_WAIT;
        end
        else if (hit_rej && answer_ok)
        begin
          next_state = S_IDLE;
        end
      end
      S_TAG_WAIT:
      begin
        if (hit_rtag && rtag_ok)
        begin
          next_state = S_IDLE;
        end
      end
      S_DATA:
      begin
        if (!tx_valid)
        begin
          next_tx_valid = 1'b1;
          next_tx_data = '{1'b1, pend_word};
          next_state = S_IDLE;
        end
      end
      S_QUERY:
      begin
        if (hit_end)
        begin
          next_state = S_IDLE;
        end
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
  end

  // =====================================================================
  // registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      tx_valid <= 1'b0;
      tx_data <= '0;
      protocol_violation_flag <= 1'b0;
      link_rejected <= 1'b0;
      cmd_refused <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      protocol_violation_flag <= viol;
      link_rejected <= hit_rej && answer_ok;
      cmd_refused <= refuse;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pend_type <= 3'h0;
      pend_word <= 16'h0000;
    end
    else if (cmd_fire)
    begin
      pend_type <= cmd.ltype;
      pend_word <= cmd.word;
    end
    else if (hit_est && state == S_IDLE)
    begin
      pend_type <= rx_type;
    end
  end

  // tags the far side announced, used to label our selections
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      link_up <= '0;
      for (int i = 0; i < `TLC_LINK_TYPES; i++)
      begin
        peer_tag[i] <= `TLC_TAG_RESET;
      end
    end
    else if ((hit_rtag && rtag_ok) || (hit_itag && tag_type_ok))
    begin
      peer_tag[rx_type] <= rx_arg;
      link_up[rx_type] <= 1'b1;
    end
    else if (hit_rej && answer_ok)
    begin
      link_up[pend_type] <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tx_link <= 3'h0;
      tx_link_set <= 1'b0;
      rx_link <= 3'h0;
    end
    else
    begin
      if (sel_sent)
      begin
        tx_link <= cmd.ltype;
        tx_link_set <= 1'b1;
      end
      if (hit_sel && sel_ok)
      begin
        rx_link <= rx_type;
      end
    end
  end
endmodule

// File: hdl/tlc_regs.svh
// tlc_regs.svh: opcodes, field positions and reset values of the tagged link handler
// assumes: included by bare name from tlc_host and tlc_host_assertions
`ifndef TLC_REGS_SVH
`define TLC_REGS_SVH

// =====================================================================
// command word layout
`define TLC_OPC_MSB 15
`define TLC_OPC_LSB 8
`define TLC_ARG_MSB 7
`define TLC_ARG_LSB 0

// =====================================================================
// opcodes, upper byte
`define TLC_OPC_ACCEPT 8'h03
`define TLC_OPC_REJECT 8'h04
`define TLC_OPC_RESP 8'h08
`define TLC_OPC_INIT_TAG 8'h0a
`define TLC_OPC_RESP_TAG 8'h0b
`define TLC_OPC_SELECT 8'h0c
`define TLC_OPC_ESTABLISH 8'h0e
`define TLC_WORD_RESP_END 16'h0900

// =====================================================================
// link types and reset values
`define TLC_LINK_TYPES 5
`define TLC_LAST_TYPE 4'h4
`define TLC_OWN_NIBBLE 4'h5
`define TLC_TAG_RESET 8'h00

`endif

// File: hdl/tlc_pkg.sv
// tlc_pkg.sv: types shared by the tagged link handler and its buffer
// assumes: tlc_regs.svh on the include path
package tlc_pkg;

  // =====================================================================
  // link types
  typedef enum logic [2:0] {
    TLC_KEYBOARD = 3'b000,
    TLC_GRAPHICS = 3'b001,
    TLC_CONTROL = 3'b010,
    TLC_STORAGE = 3'b011,
    TLC_DATA = 3'b100
  } tlc_link_e;

  // =====================================================================
  // user requests and answers
  typedef enum logic [1:0] {
    TLC_REQ_ESTABLISH = 2'b00,
    TLC_REQ_DATA = 2'b01,
    TLC_REQ_QUERY = 2'b10
  } tlc_req_e;

  typedef enum logic [1:0] {
    TLC_OUT_RESP_BYTE = 2'b00,
    TLC_OUT_RESP_END = 2'b01,
    TLC_OUT_DATA = 2'b10
  } tlc_out_e;

  typedef struct packed {
    logic is_data;
    logic [15:0] word;
  } tlc_word_s;

  typedef struct packed {
    tlc_req_e op;
    logic [2:0] ltype;
    logic [15:0] word;
  } tlc_cmd_s;

  typedef struct packed {
    tlc_out_e kind;
    logic [2:0] ltype;
    logic [15:0] word;
  } tlc_out_s;

endpackage

// File: hdl/tlc_buf.sv
// tlc_buf.sv: small valid/ready buffer, two entries by default
// assumes: one clock, synchronous active high reset
`timescale 1ns/1ps
module tlc_buf #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // =====================================================================
  // checks
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin
      $error("tlc_buf depth must be a power of two, at least two");
    end
  end

  // =====================================================================
  // storage
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty straight from the count, so a stalled reader really fills it
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: verification/tlc_host_assertions.sv
// tlc_host_assertions.sv: port checker for tlc_host
// assumes: bound onto tlc_host, one clock, sync reset
`timescale 1ns/1ps
`include "tlc_regs.svh"
module tlc_host_assertions
  import tlc_pkg::*;
#(
  parameter logic [3:0] OWN_NIBBLE = 4'h5,
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire tlc_cmd_s cmd,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire tlc_word_s tx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire tlc_word_s rx_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire tlc_out_s out_data,
  input wire logic [`TLC_LINK_TYPES-1:0] link_up,
  input wire logic protocol_violation_flag,
  input wire logic link_rejected,
  input wire logic cmd_refused
);
  // ==========================================
  // helpers
  logic pend;
  logic rx_cmd;
  logic est;
  logic [7:0] last_op;
  logic [7:0] rop;
  logic [7:0] top;
  logic [15:0] tw;
  assign rx_cmd = rx_valid && rx_ready && !rx_data.is_data;
  assign est = cmd_valid && cmd_ready && cmd.op == TLC_REQ_ESTABLISH;
  assign rop = rx_data.word[15:8];
  assign tw = tx_data.word;
  assign top = (tx_valid && !tx_data.is_data) ? tw[15:8] : 8'hff;
  // a query stays open until its terminator
  always_ff @(posedge mclk)
  begin
    if (reset)
      pend <= 1'b0;
    else if (cmd_valid && cmd_ready && cmd.op == TLC_REQ_QUERY)
      pend <= 1'b1;
    else if (rx_cmd && rx_data.word == `TLC_WORD_RESP_END)
      pend <= 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
      last_op <= 8'h00;
    else if (tx_valid && tx_ready)
      last_op <= top;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================
  // assertions
  a_est_refuse:
    assert property (est && cmd.ltype > 3'h4 |=> cmd_refused && !tx_valid)
    else $error("bad link type not refused");
  a_est_word:
    assert property (est && cmd.ltype <= 3'h4 |=> tw == {8'h0e, 5'h00, $past(cmd.ltype)})
    else $error("establish word wrong");
  a_init_tag:
    assert property (top == `TLC_OPC_INIT_TAG |-> tw[7:0] == {OWN_NIBBLE, 1'b0, tw[2:0]})
    else $error("initiator tag wrong");
  a_tag_after_acc:
    assert property (top == `TLC_OPC_INIT_TAG && !$past(tx_valid)
      |-> $past(rx_cmd && rop == `TLC_OPC_ACCEPT))
    else $error("initiator tag without acceptance");
  a_resp_tag:
    assert property (top == `TLC_OPC_RESP_TAG |-> tw[7:0] == {OWN_NIBBLE, 1'b0, tw[2:0]})
    else $error("responder tag wrong");
  a_resp_order:
    assert property (top == `TLC_OPC_RESP_TAG |-> last_op == `TLC_OPC_ACCEPT)
    else $error("responder tag not after acceptance");
  a_unsolicited:
    assert property (rx_cmd && !pend && (rop == `TLC_OPC_RESP || rx_data.word == `TLC_WORD_RESP_END)
      |=> protocol_violation_flag)
    else $error("unrequested reply not flagged");
  a_sel_known:
    assert property (top == `TLC_OPC_SELECT |-> !tw[3] && link_up[tw[2:0]])
    else $error("selection of unknown link");
  c_init: cover property (top == `TLC_OPC_INIT_TAG && tx_ready);
  c_flag: cover property (protocol_violation_flag);
  c_end: cover property (out_valid && out_ready && out_data.kind == TLC_OUT_RESP_END);
endmodule

bind tlc_host tlc_host_assertions #(.OWN_NIBBLE(OWN_NIBBLE), .BUF_DEPTH(BUF_DEPTH)) u_chk (
  .mclk, .reset, .cmd_valid, .cmd_ready, .cmd, .tx_valid, .tx_ready, .tx_data,
  .rx_valid, .rx_ready, .rx_data, .out_valid, .out_ready, .out_data, .link_up,
  .protocol_violation_flag, .link_rejected, .cmd_refused);

// File: verification/tlc_dev_model.sv
// tlc_dev_model.sv: far-side module engine answering tlc_host
// assumes: same mclk; words change just after rising edges
`timescale 1ns/1ps
module tlc_dev_model
  import tlc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow,
  input wire logic rej,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire tlc_word_s tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output tlc_word_s rx_data
);
  // ==========================================
  // state
  tlc_word_s q[$];
  logic [7:0] init_tag [0:7];
  logic [7:0] sel_tag;
  logic [7:0] resp_tag;
  logic [15:0] last_data;
  int sel_count;
  logic phase;
  logic [15:0] w;
  logic [2:0] t;
  assign w = tx_data.word;
  assign t = w[2:0];
  task automatic inject(input logic d, input logic [15:0] wd);
    q.push_back({d, wd});
  endtask
  // ==========================================
  // engine
  always @(posedge mclk)
  begin
    if (reset)
    begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= '0;
      phase <= 1'b0;
      sel_count <= 0;
      q.delete();
    end
    else
    begin
      phase <= ~phase;
      // a slow engine takes a word only every other cycle
      tx_ready <= !slow || phase;
      if (tx_valid && tx_ready && tx_data.is_data)
        last_data <= w;
      else if (tx_valid && tx_ready)
      begin
        case (w[15:8])
          8'h00:
          begin
            q.push_back({1'b0, 16'h0841});
            q.push_back({1'b0, 16'h0842});
            q.push_back({1'b0, 16'h0900});
          end
          8'h0e:
            if (rej || t > 3'h4)
              q.push_back({1'b0, 8'h04, w[7:0]});
            else
            begin
              q.push_back({1'b0, 8'h03, w[7:0]});
              q.push_back({1'b0, 8'h0b, 5'h14, t});
            end
          8'h03:
            q.push_back({1'b0, 8'h0a, 5'h18, t});
          8'h0a:
            init_tag[t] <= w[7:0];
          8'h0b:
            resp_tag <= w[7:0];
          8'h0c:
          begin
            sel_tag <= w[7:0];
            sel_count <= sel_count + 1;
          end
          default: ;
        endcase
      end
      if (!rx_valid || rx_ready)
      begin
        rx_valid <= q.size() > 0;
        // a released bus flips every bit each idle cycle, alternating between the inverse and the old word
        rx_data <= (q.size() > 0) ? q.pop_front() : ~rx_data;
      end
    end
  end
endmodule

// File: verification/tlc_host_tb_top.sv
// tlc_host_tb_top.sv: self-checking bench for tlc_host
// assumes: tlc_dev_model as far side, 40 MHz mclk
`timescale 1ns/1ps
module tlc_host_tb_top;
  import tlc_pkg::*;
  logic mclk, reset, cmd_valid, cmd_ready, tx_valid, tx_ready, rx_valid, rx_ready;
  logic out_valid, out_ready, pvf, lrej, cref, slow, rej;
  logic [4:0] link_up;
  tlc_cmd_s cmd;
  tlc_word_s tx_data, rx_data;
  tlc_out_s out_data, o;
  int bad_count, samples_checked, n_pv, n_lr, n_cr, n, c;
  tlc_host #(.OWN_NIBBLE(4'h5)) u_dut (.mclk, .reset, .cmd_valid, .cmd_ready, .cmd,
    .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .out_valid,
    .out_ready, .out_data, .link_up, .protocol_violation_flag(pvf),
    .link_rejected(lrej), .cmd_refused(cref));
  tlc_dev_model u_dev (.mclk, .reset, .slow, .rej, .tx_valid, .tx_ready, .tx_data,
    .rx_valid, .rx_ready, .rx_data);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    n_pv += (pvf === 1'b1);
    n_lr += (lrej === 1'b1);
    n_cr += (cref === 1'b1);
  end
  // ==========================================
  // helpers
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
      bad_count++;
    if (seen !== exp)
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
  endtask
  // a wait limit that runs out counts as a mismatch
  task automatic lost(input bit hit);
    if (hit)
    begin
      bad_count++;
      $display("FAIL %0t wait limit ran out", $time);
    end
  endtask
  task automatic send_cmd(input tlc_req_e op, input logic [2:0] lt, input logic [15:0] wd);
    cmd <= '{op, lt, wd};
    cmd_valid <= 1'b1;
    n = 0;
    do
      @(posedge mclk);
    while (cmd_ready !== 1'b1 && ++n < 200);
    cmd_valid <= 1'b0;
    // one idle edge, so back-to-back calls never rewrite valid in one step
    @(posedge mclk);
    lost(n >= 200);
  endtask
  task automatic settle;
    n = 0;
    c = 0;
    while (c < 3 && ++n < 300)
    begin
      @(posedge mclk);
      c = (cmd_ready === 1'b1) ? c + 1 : 0;
    end
    lost(n >= 300);
  endtask
  task automatic take_out;
    n = 0;
    do
      @(posedge mclk);
    while (!(out_valid === 1'b1 && out_ready === 1'b1) && ++n < 100);
    o = out_data;
    lost(n >= 100);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reject_refuse;
    rej <= 1'b1;
    send_cmd(TLC_REQ_ESTABLISH, 3'h1, 16'h0000);
    settle();
    check(n_lr, 1);
    check(link_up, 5'h00);
    rej <= 1'b0;
    send_cmd(TLC_REQ_ESTABLISH, 3'h5, 16'h0000);
    send_cmd(TLC_REQ_DATA, 3'h1, 16'h55aa);
    send_cmd(TLC_REQ_DATA, 3'h7, 16'h55aa);
    settle();
    check(n_cr, 3);
  endtask
  task automatic t_establish;
    for (int i = 0; i < 5; i++)
    begin
      slow <= i[0];
      send_cmd(TLC_REQ_ESTABLISH, i[2:0], 16'h0000);
      settle();
      check(link_up[i], 1'b1);
      check(u_dev.init_tag[i], {5'h0a, i[2:0]});
    end
    slow <= 1'b0;
  endtask
  task automatic t_query;
    out_ready <= 1'b0;
    send_cmd(TLC_REQ_QUERY, 3'h0, 16'h0001);
    n = 0;
    while (!(rx_valid === 1'b1 && rx_ready === 1'b0 && cmd_ready === 1'b0) && ++n < 50)
      @(posedge mclk);
    lost(n >= 50);
    repeat (4) @(posedge mclk);
    out_ready <= 1'b1;
    take_out();
    check({o.kind, o.word[7:0]}, {TLC_OUT_RESP_BYTE, 8'h41});
    take_out();
    check({o.kind, o.word[7:0]}, {TLC_OUT_RESP_BYTE, 8'h42});
    take_out();
    check(o.kind, TLC_OUT_RESP_END);
    check(n_pv, 0);
  endtask
  task automatic t_data;
    int sc;
    send_cmd(TLC_REQ_DATA, 3'h2, 16'h1234);
    settle();
    check(u_dev.sel_tag, 8'ha2);
    check(u_dev.last_data, 16'h1234);
    sc = u_dev.sel_count;
    send_cmd(TLC_REQ_DATA, 3'h2, 16'h5678);
    settle();
    check(u_dev.sel_count - sc, 0);
    send_cmd(TLC_REQ_DATA, 3'h4, 16'h9abc);
    settle();
    check({u_dev.sel_tag, u_dev.last_data}, 24'ha49abc);
  endtask
  task automatic t_incoming;
    u_dev.inject(1'b0, 16'h0e03);
    settle();
    check(u_dev.resp_tag, 8'h53);
    u_dev.inject(1'b0, 16'h0c53);
    u_dev.inject(1'b1, 16'hbeef);
    take_out();
    check({o.kind, o.ltype, o.word}, {TLC_OUT_DATA, 3'h3, 16'hbeef});
  endtask
  task automatic t_violation;
    u_dev.inject(1'b0, 16'h0841);
    u_dev.inject(1'b0, 16'h0900);
    u_dev.inject(1'b0, 16'h0c33);
    settle();
    check(n_pv, 3);
  endtask
  initial
  begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    out_ready = 1'b1;
    slow = 1'b0;
    rej = 1'b0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reject_refuse();
    t_establish();
    t_query();
    t_data();
    t_incoming();
    t_violation();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("FAIL %0t watchdog expired", $time);
    test_done();
  end
endmodule
